/* File: asram_pkg.sv */
// shared constants and carriers for the async static memory controller
package asram_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned DATA_W = 8;
    // speed grade selection: 1 = 45 ns part, 0 = 55 ns part
    localparam bit FAST_GRADE = 1'b1;
    // times in ns, as printed
    localparam int unsigned READ_PERIOD_NS = FAST_GRADE ? 45 : 55;
    localparam int unsigned ADDRESS_ACCESS_DELAY_NS = FAST_GRADE ? 45 : 55;
    localparam int unsigned SELECT_ACCESS_DELAY_NS = FAST_GRADE ? 45 : 55;
    localparam int unsigned GATE_ACCESS_DELAY_NS = FAST_GRADE ? 22 : 25;
    localparam int unsigned OUTPUT_HOLD_AFTER_ADDRESS_NS = 10;
    localparam int unsigned POWERDOWN_DELAY_NS = FAST_GRADE ? 45 : 55;
    localparam int unsigned WRITE_PERIOD_NS = FAST_GRADE ? 45 : 55;
    localparam int unsigned STROBE_LOW_WIDTH_NS = FAST_GRADE ? 35 : 40;
    localparam int unsigned ADDRESS_LEAD_TO_WRITE_END_NS = FAST_GRADE ? 35 : 40;
    localparam int unsigned ADDRESS_LEAD_TO_WRITE_START_NS = 0;
    localparam int unsigned ADDRESS_HOLD_AFTER_WRITE_NS = 0;
    localparam int unsigned DATA_LEAD_TO_WRITE_END_NS = 25;
    localparam int unsigned DATA_HOLD_AFTER_WRITE_NS = 0;
    localparam int unsigned STROBE_TO_FLOAT_DELAY_NS = FAST_GRADE ? 18 : 20;
    // least times round up, no count below one cycle
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    // read: data sampled after the slowest of address and select access
    localparam int unsigned READ_ACCESS_CYC = ns_to_cyc(
        (ADDRESS_ACCESS_DELAY_NS > SELECT_ACCESS_DELAY_NS) ?
        ADDRESS_ACCESS_DELAY_NS : SELECT_ACCESS_DELAY_NS) + 1;
    localparam int unsigned READ_PERIOD_CYC = ns_to_cyc(READ_PERIOD_NS);
    // write strobe width covers setup plus float time, and the low width
    localparam int unsigned STROBE_MIN_NS =
        DATA_LEAD_TO_WRITE_END_NS + STROBE_TO_FLOAT_DELAY_NS;
    localparam int unsigned STROBE_CYC = ns_to_cyc(
        (STROBE_MIN_NS > STROBE_LOW_WIDTH_NS) ?
        STROBE_MIN_NS : STROBE_LOW_WIDTH_NS);
    localparam int unsigned WRITE_PERIOD_CYC = ns_to_cyc(WRITE_PERIOD_NS);
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    typedef enum logic [3:0] {
        ASRAM_IDLE  = 4'b0001,
        ASRAM_READ  = 4'b0010,
        ASRAM_WRITE = 4'b0100,
        ASRAM_GAP   = 4'b1000
    } asram_state_t;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asram_req_t;

    typedef struct packed {
        logic              primary_select_n;
        logic              secondary_select;
        logic              write_strobe_n;
        logic              output_gate_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } asram_pins_t;
endpackage

/* File: asram_timer.sv */
// down counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ps
`default_nettype none
module asram_timer
    import asram_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] count_in,
    output logic                  done_out
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } asram_tmr_t;

    asram_tmr_t st_q;
    asram_tmr_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (load_in) begin
            st_d.cnt = count_in;
        end else if (st_q.cnt != CNT_ZERO) begin
            st_d.cnt = st_q.cnt - CNT_ONE;
            st_d.done = (st_q.cnt == CNT_ONE);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_out = st_q.done;
endmodule
`default_nettype wire

/* File: asram_ctrl.sv */
// controller driving an async static memory over its pins
//
// Functional notes
// - write starts with all qualifiers active; dropping one ends it.
// - data setup and hold measured from the write-ending edge.
// - address stable at least 35/40 ns before write end.
// - write address valid no later than write start.
// - address unchanged until the write has ended.
// - write data valid at least 25 ns before write end.
// - write data kept driven until the write-ending edge.
// - strobe pulse at least data setup plus strobe-to-float delay.
// - selected with strobe high and gate low reads; strobe low writes.
// - controller never drives data pins while memory drives them.
`timescale 1ns/1ps
`default_nettype none
module asram_ctrl
    import asram_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              req_valid_in,
    input  wire asram_req_t        req_in,
    output logic                   req_ready_out,
    output logic                   rdata_valid_out,
    output logic [DATA_W-1:0]      rdata_out,
    output logic                   write_done_out,
    output logic                   primary_select_n_out,
    output logic                   secondary_select_out,
    output logic                   write_strobe_n_out,
    output logic                   output_gate_n_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_out,
    input  wire logic [DATA_W-1:0] dq_in
);
    localparam logic [CNT_W-1:0] READ_ACC_CNT = CNT_W'(READ_ACCESS_CYC);
    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
    // gap pads each cycle out to its full period
    localparam logic [CNT_W-1:0] READ_GAP_CNT =
        CNT_W'((READ_PERIOD_CYC > READ_ACCESS_CYC) ?
        READ_PERIOD_CYC - READ_ACCESS_CYC : 1);
    localparam logic [CNT_W-1:0] WRITE_GAP_CNT =
        CNT_W'((WRITE_PERIOD_CYC > STROBE_CYC) ?
        WRITE_PERIOD_CYC - STROBE_CYC : 1);

    typedef struct packed {
        asram_state_t      state;
        asram_pins_t       pins;
        logic              ready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic              wdone;
    } asram_ctl_t;

    asram_ctl_t       st_q;
    asram_ctl_t       st_d;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic             tmr_done;

    asram_timer i_asram_timer (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (tmr_load),
        .count_in   (tmr_count),
        .done_out   (tmr_done)
    );

    always_comb begin
        st_d = st_q;
        tmr_load = 1'b0;
        tmr_count = CNT_ZERO;
        st_d.rvalid = 1'b0;
        st_d.wdone = 1'b0;
        unique case (st_q.state)
            ASRAM_IDLE: begin
                if (req_valid_in && st_q.ready) begin
                    st_d.ready = 1'b0;
                    // address and select in the same edge, data on the same edge as strobe
                    st_d.pins.addr = req_in.addr;
                    st_d.pins.primary_select_n = 1'b0;
                    st_d.pins.secondary_select = 1'b1;
                    tmr_load = 1'b1;
                    if (req_in.write) begin
                        st_d.pins.output_gate_n = 1'b1;
                        st_d.pins.write_strobe_n = 1'b0;
                        st_d.pins.dq_out = req_in.wdata;
                        st_d.pins.dq_oe = 1'b1;
                        // strobe length also gives the address lead
                        tmr_count = STROBE_CNT;
                        st_d.state = ASRAM_WRITE;
                    end else begin
                        st_d.pins.dq_oe = 1'b0;
                        st_d.pins.write_strobe_n = 1'b1;
                        st_d.pins.output_gate_n = 1'b0;
                        tmr_count = READ_ACC_CNT;
                        st_d.state = ASRAM_READ;
                    end
                end
            end
            ASRAM_READ: begin
                if (tmr_done) begin
                    // sampled while address still held, inside hold window
                    st_d.rdata = dq_in;
                    st_d.rvalid = 1'b1;
                    st_d.pins.primary_select_n = 1'b1;
                    st_d.pins.secondary_select = 1'b0;
                    st_d.pins.output_gate_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = READ_GAP_CNT;
                    st_d.state = ASRAM_GAP;
                end
            end
            ASRAM_WRITE: begin
                if (tmr_done) begin
                    // strobe ends the write; address, data kept this edge
                    st_d.pins.write_strobe_n = 1'b1;
                    st_d.wdone = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = WRITE_GAP_CNT;
                    st_d.state = ASRAM_GAP;
                end
            end
            ASRAM_GAP: begin
                // data and select released one cycle after strobe rises
                st_d.pins.dq_oe = 1'b0;
                st_d.pins.primary_select_n = 1'b1;
                st_d.pins.secondary_select = 1'b0;
                if (tmr_done) begin
                    st_d.ready = 1'b1;
                    st_d.state = ASRAM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
            st_q.state <= ASRAM_IDLE;
            st_q.ready <= 1'b1;
            st_q.pins.primary_select_n <= 1'b1;
            st_q.pins.write_strobe_n <= 1'b1;
            st_q.pins.output_gate_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign req_ready_out = st_q.ready;
    assign rdata_valid_out = st_q.rvalid;
    assign rdata_out = st_q.rdata;
    assign write_done_out = st_q.wdone;
    assign primary_select_n_out = st_q.pins.primary_select_n;
    assign secondary_select_out = st_q.pins.secondary_select;
    assign write_strobe_n_out = st_q.pins.write_strobe_n;
    assign output_gate_n_out = st_q.pins.output_gate_n;
    assign addr_out = st_q.pins.addr;
    assign dq_out = st_q.pins.dq_out;
    assign dq_oe_out = st_q.pins.dq_oe;
endmodule
`default_nettype wire

/* File: asram_ctrl_assertions.sv */
// pin-level checks on the static memory controller
`timescale 1ns/1ps
`default_nettype none
module asram_chk
    import asram_pkg::*;
(
    input wire logic              mclk_in,
    input wire logic              sys_rst_in,
    input wire logic              rdata_valid_out,
    input wire logic              write_done_out,
    input wire logic              primary_select_n_out,
    input wire logic              secondary_select_out,
    input wire logic              write_strobe_n_out,
    input wire logic              output_gate_n_out,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe_out
);
    wire logic sel  = !primary_select_n_out && secondary_select_out;
    wire logic we_n = write_strobe_n_out;
    wire logic oe_n = output_gate_n_out;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_select_pair: assert property (
        primary_select_n_out == !secondary_select_out) else $error("split");
    a_write_select: assert property (!we_n |-> sel)
        else $error("strobe without select");
    a_no_clash: assert property (!oe_n |-> !dq_oe_out)
        else $error("bus driven during read");
    a_write_hold: assert property (!we_n && $past(!we_n) |->
        $stable(addr_out) && $stable(dq_out)) else $error("moved in write");
    a_strobe_width: assert property ($fell(we_n) |=> !we_n [*8])
        else $error("strobe too short");
    a_addr_lead: assert property ($rose(we_n) |->
        $past(addr_out, 7) == addr_out) else $error("address lead");
    a_data_lead: assert property ($rose(we_n) |->
        $past(dq_out, 5) == dq_out && $past(dq_oe_out, 5))
        else $error("data lead");
    a_done_end: assert property (
        write_done_out |-> $rose(we_n) && sel)
        else $error("done without write end");
    a_read_time: assert property ($fell(oe_n) |=>
        !rdata_valid_out [*8] ##[1:4] rdata_valid_out)
        else $error("read latency");
    a_read_space: assert property ($fell(primary_select_n_out) |=>
        !$fell(primary_select_n_out) [*8]) else $error("access spacing");
    a_rvalid_gate: assert property (rdata_valid_out |->
        $past(!oe_n) && $past(we_n)) else $error("read without gate");
    c_write: cover property ($rose(we_n) && sel);
    c_read: cover property (rdata_valid_out);
    c_two: cover property (write_done_out ##[1:30] rdata_valid_out);
endmodule
`default_nettype wire

/* File: asram_mem_model.sv */
// behavioural static memory with timing checks on its controller
`timescale 1ns/1ps
`default_nettype none
module asram_mem
    import asram_pkg::*;
(
    input  wire logic              primary_select_n_in,
    input  wire logic              secondary_select_in,
    input  wire logic              write_strobe_n_in,
    input  wire logic              output_gate_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              bus_oe_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   drive_out,
    output var int                 viol_out
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    realtime           t_a = 0, t_d = 0, t_s = -100, t_w = 0, t_g = 0;
    // unknown to low at controller reset is no write end
    bit                wr_open = 1'b0;
    wire logic sel = !primary_select_n_in && secondary_select_in;
    wire logic wr  = sel && !write_strobe_n_in;
    initial viol_out = 0;
    initial data_out = '0;
    always @(addr_in) t_a = $realtime;
    always @(data_in) t_d = $realtime;
    always @(negedge output_gate_n_in) t_g = $realtime;
    always @(posedge wr) begin
        t_w = $realtime;
        wr_open = 1'b1;
    end
    always @(posedge sel) begin
        if ($realtime - t_s < READ_PERIOD_NS)
            viol_out++;
        t_s = $realtime;
    end
    always @(negedge wr) begin
        if (wr_open) begin
            if ($realtime - t_a < ADDRESS_LEAD_TO_WRITE_END_NS)
                viol_out++;
            if ($realtime - t_d < DATA_LEAD_TO_WRITE_END_NS)
                viol_out++;
            if ($realtime - t_w < STROBE_MIN_NS)
                viol_out++;
            mem[addr_in] = data_in;
        end
        wr_open = 1'b0;
    end
    always begin
        #1;
        drive_out = sel && write_strobe_n_in && !output_gate_n_in;
        if (drive_out && bus_oe_in)
            viol_out++;
        if (drive_out && $realtime >= t_a + ADDRESS_ACCESS_DELAY_NS
            && $realtime >= t_s + SELECT_ACCESS_DELAY_NS
            && $realtime >= t_g + GATE_ACCESS_DELAY_NS)
            data_out = mem[addr_in];
        else
            data_out = ~data_out; // floating or not yet valid
    end
endmodule
`default_nettype wire

/* File: test_asram_ctrl.sv */
// self-checking bench for the static memory controller
`timescale 1ns/1ps
`default_nettype none
module test_asram_ctrl
    import asram_pkg::*;
;
    logic                   mclk_in = 1'b0;
    logic                   sys_rst_in = 1'b1;
    logic                   req_valid_in = 1'b0;
    asram_req_t             req_in = '0;
    logic                   ready, rvalid, wdone, p_n, s, we_n, oe_n;
    logic                   oe, m_drv;
    logic [DATA_W-1:0]      rdata, dq_o, m_dat;
    logic [ADDR_W-1:0]      addr;
    wire logic [DATA_W-1:0] bus = oe ? dq_o : m_dat;
    int                     viol, lat, miscompares = 0, cmp_count = 0, cyc = 0;
    asram_ctrl i_asram_ctrl (.mclk_in, .sys_rst_in, .req_valid_in, .req_in,
        .req_ready_out(ready), .rdata_valid_out(rvalid), .rdata_out(rdata),
        .write_done_out(wdone), .primary_select_n_out(p_n),
        .secondary_select_out(s), .write_strobe_n_out(we_n),
        .output_gate_n_out(oe_n), .addr_out(addr), .dq_out(dq_o),
        .dq_oe_out(oe), .dq_in(bus));
    asram_mem i_asram_mem (.primary_select_n_in(p_n),
        .secondary_select_in(s), .write_strobe_n_in(we_n),
        .output_gate_n_in(oe_n), .addr_in(addr), .data_in(bus),
        .bus_oe_in(oe), .data_out(m_dat), .drive_out(m_drv),
        .viol_out(viol));
    initial forever #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic check(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bog: a second request is offered while the first is still busy
    task automatic op(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic bog);
        req_in       <= '{w, a, d};
        req_valid_in <= 1'b1;
        @(posedge mclk_in);
        while (ready !== 1'b1) @(posedge mclk_in);
        req_valid_in <= bog;
        req_in.wdata <= ~d;
        lat = 0;
        do begin
            @(posedge mclk_in);
            // cleared once only, so the next call may raise it
            if (lat == 0) begin
                req_valid_in <= 1'b0;
            end
            lat++;
        end while ((w ? wdone : rvalid) !== 1'b1 && lat < 40);
        check(lat < 40, "no completion");
    endtask
    task automatic t_reset();
        check(p_n === 1'b1 && s === 1'b0, "select at reset");
        check(we_n === 1'b1 && oe_n === 1'b1, "strobes at reset");
        check(oe === 1'b0 && m_drv === 1'b0 && ready === 1'b1,
              "bus at reset");
        $display("reset test done");
    endtask
    task automatic t_rw();
        logic [ADDR_W-1:0] a [3] = '{17'h0_0000, 17'h1_FFFF, 17'h0_AAAA};
        logic [DATA_W-1:0] d [3] = '{8'hA5, 8'h5A, 8'hFF};
        int unsigned       min_lat = ADDRESS_ACCESS_DELAY_NS * 1000 /
                                     CLK_PERIOD_PS;
        foreach (a[i]) op(1'b1, a[i], d[i], 1'b0);
        for (int i = 2; i >= 0; i--) begin
            op(1'b0, a[i], 8'h00, 1'b0);
            check(rvalid === 1'b1 && rdata === d[i], "read data");
            check(lat >= min_lat, "read too early");
        end
        $display("write and read test done");
    endtask
    task automatic t_refused();
        op(1'b1, 17'h0_0F0F, 8'h3C, 1'b1);
        op(1'b0, 17'h0_0F0F, 8'h00, 1'b1);
        check(rdata === 8'h3C, "request taken while busy");
        $display("busy refusal test done");
    endtask
    initial begin
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        t_reset();
        t_rw();
        t_refused();
        check(viol == 0, "memory timing");
        end_sim();
    end
endmodule
bind asram_ctrl asram_chk i_asram_chk (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .rdata_valid_out(rdata_valid_out),
    .write_done_out(write_done_out),
    .primary_select_n_out(primary_select_n_out),
    .secondary_select_out(secondary_select_out),
    .write_strobe_n_out(write_strobe_n_out),
    .output_gate_n_out(output_gate_n_out), .addr_out(addr_out),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out));
`default_nettype wire
